/* core/trig_source_select.sv */
/*
  Trigger source selector for the event group and group 1 of a buffered converter.
  Assumes a one-cycle register port and trigger inputs synchronous enough to sample.
*/
// Summary of operation
// R1 - Group 1 enable bit 8 low means software start only, high means hardware.
// R2 - Group 1 edge bit 7: zero means falling edge, one means rising edge.
// R3 - Group 1 source bits 5-4: 00 pin, 01-11 one of three timer outputs.
// R4 - Event source bits 1-0: 00 pin, 01-11 one of three timer outputs.
// R5 - Event group polarity comes from bit 8 of second control register.
// R6 - Four trigger inputs are shared; each code picks one input for both.
// R7 - Reserved bits 15-9, 6, 3-2 ignore writes; reads are zero.
// R8 - Selection works the same in compatibility and buffered modes.
// R9 - Chosen input is synchronised, edge detected, and gives one-cycle start.
`include "trig_sel_defines.svh"

module trig_source_select
  import trig_sel_pkg::*;
#(
  parameter int NUM_TIMERS = `TSS_NUM_SRC - 1
)
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [`TSS_ADDR_W-1:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [15:0] RDATA,
  input wire logic EXT_TRIG_PIN,
  input wire logic [NUM_TIMERS-1:0] TIMER_TRIG,
  input wire logic G1_SW_START,
  output logic EV_START,
  output logic G1_START,
  output logic BUFFERED_MODE
);
  import trig_sel_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic g1_ena_q;
  logic g1_pol_q;
  src_code_t g1_src_q;
  src_code_t ev_src_q;
  logic ev_pol_q;
  logic buf_mode_q;
  logic [15:0] rdata_q;
  logic g1_sw_q;
  logic [15:0] rdata_d;
  logic wr_src;
  logic wr_ctrl2;
  logic wr_mode;
  logic [NUM_TIMERS:0] sources;
  logic ev_start_raw;
  logic g1_hw_start;
  g1_mode_t g1_mode;

  // Address decode; only defined fields are stored, reserved bits are dropped.
  assign wr_src = WR && (ADDR == `TSS_OFS_SRC_SEL);
  assign wr_ctrl2 = WR && (ADDR == `TSS_OFS_CTRL2);
  assign wr_mode = WR && (ADDR == `TSS_OFS_MODE);

  // Read mux; unmapped addresses and reserved bits read as zero.
  always_comb
  begin
    rdata_d = 16'h0000;
    if (ADDR == `TSS_OFS_SRC_SEL)
    begin
      rdata_d[`TSS_BIT_G1_ENA] = g1_ena_q;
      rdata_d[`TSS_BIT_G1_POL] = g1_pol_q;
      rdata_d[`TSS_MSB_G1_SRC:`TSS_LSB_G1_SRC] = g1_src_q;
      rdata_d[`TSS_MSB_EV_SRC:`TSS_LSB_EV_SRC] = ev_src_q; // R7
    end
    else if (ADDR == `TSS_OFS_CTRL2)
    begin
      rdata_d[`TSS_BIT_EV_POL] = ev_pol_q;
    end
    else if (ADDR == `TSS_OFS_MODE)
    begin
      rdata_d[`TSS_BIT_BUF_MODE] = buf_mode_q;
    end
  end

  // Register writes; the mode bit does not gate the selector.
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      g1_ena_q <= 1'b0;
      g1_pol_q <= 1'b0;
      g1_src_q <= 2'h0;
      ev_src_q <= 2'h0;
      ev_pol_q <= 1'b0;
      buf_mode_q <= 1'b0;
    end
    else
    begin
      if (wr_src)
      begin
        g1_ena_q <= WDATA[`TSS_BIT_G1_ENA]; // R1
        g1_pol_q <= WDATA[`TSS_BIT_G1_POL]; // R2
        g1_src_q <= WDATA[`TSS_MSB_G1_SRC:`TSS_LSB_G1_SRC]; // R3
        ev_src_q <= WDATA[`TSS_MSB_EV_SRC:`TSS_LSB_EV_SRC]; // R4 R7
      end
      if (wr_ctrl2)
      begin
        ev_pol_q <= WDATA[`TSS_BIT_EV_POL]; // R5
      end
      if (wr_mode)
      begin
        buf_mode_q <= WDATA[`TSS_BIT_BUF_MODE]; // R8
      end
    end
  end

  // Read data appears only in the cycle after the read strobe.
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      rdata_q <= 16'h0000;
    end
    else
    begin
      rdata_q <= RD ? rdata_d : 16'h0000;
    end
  end

  // ----------------------------------------------------------------
  // Trigger channels
  // ----------------------------------------------------------------
  // Index 0 is the pin, 1 to 3 are timer outputs, shared by both groups.
  assign sources = {TIMER_TRIG, EXT_TRIG_PIN}; // R3 R4 R6

  // Group 1 mode from its enable bit.
  assign g1_mode = g1_ena_q ? G1_EVENT : G1_SOFT; // R1

  trig_edge_detect #(.NUM_SRC(NUM_TIMERS + 1)) u_ev_chan (
    .clk(REF_CLK),
    .rst(RESET),
    .sources(sources),
    .sel(ev_src_q),
    .pol(edge_pol_t'(ev_pol_q)),
    .enable(1'b1),
    .start(ev_start_raw)
  );

  trig_edge_detect #(.NUM_SRC(NUM_TIMERS + 1)) u_g1_chan (
    .clk(REF_CLK),
    .rst(RESET),
    .sources(sources),
    .sel(g1_src_q),
    .pol(edge_pol_t'(g1_pol_q)),
    .enable(g1_ena_q),
    .start(g1_hw_start)
  );

  // Start outputs registered; group 1 software start works only in software mode.
  always_ff @(posedge REF_CLK or posedge RESET)
  begin
    if (RESET)
    begin
      g1_sw_q <= 1'b0;
      EV_START <= 1'b0;
      G1_START <= 1'b0;
      BUFFERED_MODE <= 1'b0;
    end
    else
    begin
      g1_sw_q <= G1_SW_START;
      EV_START <= ev_start_raw;
      BUFFERED_MODE <= buf_mode_q;
      unique case (g1_mode)
        G1_SOFT: G1_START <= g1_sw_q; // R1
        G1_EVENT: G1_START <= g1_hw_start; // R1 R2
        default: G1_START <= 1'b0;
      endcase
    end
  end

  assign RDATA = rdata_q;

endmodule : trig_source_select

/* include/trig_sel_defines.svh */
/*
  Offsets, field positions, reset values and sizes for the trigger source selector.
  Assumes a plain register port with word-indexed addresses matching the printed offsets.
*/
`ifndef TRIG_SEL_DEFINES_SVH
`define TRIG_SEL_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define TSS_ADDR_W 8
`define TSS_OFS_SRC_SEL 8'hD8
`define TSS_OFS_CTRL2 8'hDC
`define TSS_OFS_MODE 8'hE0

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define TSS_BIT_G1_ENA 8
`define TSS_BIT_G1_POL 7
`define TSS_MSB_G1_SRC 5
`define TSS_LSB_G1_SRC 4
`define TSS_MSB_EV_SRC 1
`define TSS_LSB_EV_SRC 0
`define TSS_BIT_EV_POL 8
`define TSS_BIT_BUF_MODE 0

// ----------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------
`define TSS_RST_SRC_SEL 16'h0000
`define TSS_RST_CTRL2 16'h0000
`define TSS_NUM_SRC 4

`endif

/* include/trig_sel_pkg.sv */
/*
  Types shared by the trigger source selector files.
  Assumes trig_sel_defines.svh is on the include path.
*/
package trig_sel_pkg;

  // Source selection code: 0 is the pin, 1 to 3 the timer outputs.
  typedef logic [1:0] src_code_t;

  // Polarity of the qualifying edge.
  typedef enum logic {POL_FALL = 1'b0, POL_RISE = 1'b1} edge_pol_t;

  // Group 1 trigger mode, one-hot.
  typedef enum logic [1:0] {G1_SOFT = 2'b01, G1_EVENT = 2'b10} g1_mode_t;

endpackage : trig_sel_pkg

/* core/trig_edge_detect.sv */
/*
  One trigger channel: picks a source, synchronises it and flags the chosen edge.
  Assumes the four trigger inputs are shared and indexed the same for every channel.
*/
`include "trig_sel_defines.svh"

module trig_edge_detect
  import trig_sel_pkg::*;
#(
  parameter int NUM_SRC = `TSS_NUM_SRC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [NUM_SRC-1:0] sources,
  input wire trig_sel_pkg::src_code_t sel,
  input wire trig_sel_pkg::edge_pol_t pol,
  input wire logic enable,
  output logic start
);
  import trig_sel_pkg::*;

  // ----------------------------------------------------------------
  // Selection and edge detection
  // ----------------------------------------------------------------
  logic sync1_q;
  logic sync2_q;
  logic prev_q;
  logic start_q;
  logic picked;
  logic rise;
  logic fall;
  logic hit;

  // The same code picks the same input in every channel.
  assign picked = sources[sel]; // R6
  assign rise = sync2_q & ~prev_q;
  assign fall = ~sync2_q & prev_q;
  assign hit = enable & ((pol == POL_RISE) ? rise : fall); // R2 R5 R9
  assign start = start_q;

  // Two-stage synchroniser, history flop and a one-cycle start pulse.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
      start_q <= 1'b0;
    end
    else
    begin
      sync1_q <= picked; // R9
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
      start_q <= hit; // R9
    end
  end

endmodule : trig_edge_detect

/* dv/trig_sel_chk.sv */
/* Assertions on the trigger source selector ports.
   Assumes binding to the top module with the same port names. */
module trig_sel_chk
(
  input wire logic REF_CLK,
  input wire logic RESET,
  input wire logic [7:0] ADDR,
  input wire logic [15:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  input wire logic [15:0] RDATA,
  input wire logic EV_START,
  input wire logic G1_START,
  input wire logic BUFFERED_MODE
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RESET);
  property p_ev_pulse; EV_START |=> !EV_START; endproperty
  a_ev_pulse: assert property (p_ev_pulse) else $error("event start too long");
  property p_g1_pulse; G1_START |=> !G1_START; endproperty
  a_g1_pulse: assert property (p_g1_pulse) else $error("group 1 start too long");
  property p_rst_quiet; $fell(RESET) |-> !EV_START && !G1_START; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("start after reset");
  // The mode bit is stored one edge after the write and mirrored one edge later.
  property p_mode; $changed(BUFFERED_MODE) |-> $past(WR, 2) && $past(ADDR, 2) == 8'hE0; endproperty
  a_mode: assert property (p_mode) else $error("mode changed without write");
  property p_src_rb;
    WR && ADDR == 8'hD8 ##1 RD && ADDR == 8'hD8 |=> RDATA == ($past(WDATA, 2) & 16'h01B3);
  endproperty
  a_src_rb: assert property (p_src_rb) else $error("source readback wrong");
  property p_pol_rb;
    WR && ADDR == 8'hDC ##1 RD && ADDR == 8'hDC |=> RDATA == ($past(WDATA, 2) & 16'h0100);
  endproperty
  a_pol_rb: assert property (p_pol_rb) else $error("polarity readback wrong");
  property p_unmap; RD && ADDR == 8'h10 |=> RDATA == 16'h0000; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_idle; !RD |=> RDATA == 16'h0000; endproperty
  a_idle: assert property (p_idle) else $error("read data outside read");
endmodule : trig_sel_chk

/* dv/trig_src_partner.sv */
/* Far-side model of the trigger pin and the three timer outputs.
   Assumes the bench names a source code and its level each cycle. */
module trig_src_partner
(
  input wire logic clk,
  input wire logic [1:0] code,
  input wire logic lvl,
  output logic pin,
  output logic [2:0] tmr
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] src_q = 4'h0;
  // Code 0 is the pin, codes 1 to 3 the timers, one set for both groups.
  always_ff @(posedge clk) src_q[code] <= lvl;
  assign pin = src_q[0];
  assign tmr = src_q[3:1];
endmodule : trig_src_partner

/* dv/adc_trigger_source_select_bench.sv */
/* Self-checking bench for the trigger source selector.
   Assumes the partner model drives the four trigger inputs. */
module adc_trigger_source_select_bench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, rst = 1, wr = 0, rd = 0, sw = 0, lvl = 0, pin, ev, g1, bm;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000, rdata;
  logic [1:0] code = 2'h0;
  logic [2:0] tmr;
  int error_cnt = 0, cmp_count = 0, cyc = 0, nev, ng1, g, c, p, m;
  trig_source_select dut (.REF_CLK(clk), .RESET(rst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .EXT_TRIG_PIN(pin), .TIMER_TRIG(tmr),
    .G1_SW_START(sw), .EV_START(ev), .G1_START(g1), .BUFFERED_MODE(bm));
  trig_src_partner far (.clk(clk), .code(code), .lvl(lvl), .pin(pin), .tmr(tmr));
  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wreg(input logic [7:0] a, input logic [15:0] d);
    addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
  endtask : wreg
  task rreg(input logic [7:0] a, input logic [15:0] e);
    addr <= a; rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) chk(rdata, e);
    @(posedge clk);
  endtask : rreg
  // Counts start pulses; an unknown level counts far beyond any expected number.
  task cnt;
    nev = 0;
    ng1 = 0;
    repeat (8)
    begin
      @(negedge clk);
      nev += (ev === 1'b1) ? 1 : ((ev === 1'b0) ? 0 : 100);
      ng1 += (g1 === 1'b1) ? 1 : ((g1 === 1'b0) ? 0 : 100);
    end
    @(posedge clk);
  endtask : cnt
  function automatic int hits(input int sel, input int pol, input int s, input int l);
    return int'(sel == s && pol == l);
  endfunction : hits
  // Moves one source to a level and counts the starts of both groups.
  task src(input int s, input int l);
    code <= s[1:0]; lvl <= l[0];
    cnt;
    chk(16'(nev), 16'(hits(g ? 0 : c, g ? 0 : p, s, l)));
    chk(16'(ng1), 16'(g ? hits(c, p, s, l) : 0));
  endtask : src
  task swp(input int e);
    sw <= 1'b1;
    @(posedge clk) sw <= 1'b0;
    cnt;
    chk(16'(ng1), 16'(e));
  endtask : swp
  task t_regs;
    rreg(8'hD8, 16'h0000);
    wreg(8'hD8, 16'hFFFF);
    rreg(8'hD8, 16'h01B3);
    wreg(8'hDC, 16'hFFFF);
    rreg(8'hDC, 16'h0100);
    rreg(8'h10, 16'h0000);
    swp(0);
    wreg(8'hD8, 16'h0000);
    swp(1);
  endtask : t_regs
  task t_trig;
    for (m = 0; m < 2; m++)
    begin
      wreg(8'hE0, 16'(m));
      rreg(8'hE0, 16'(m));
      chk(16'(bm), 16'(m));
      for (g = 0; g < 2; g++) for (c = 0; c < 4; c++) for (p = 0; p < 2; p++)
      begin
        wreg(8'hD8, g ? 16'h0100 | 16'(p << 7) | 16'(c << 4) : 16'(c));
        // One idle edge so the write strobe is not driven twice in one step.
        @(posedge clk);
        wreg(8'hDC, g ? 16'h0000 : 16'(p << 8));
        src((c + 1) % 4, 1);
        src((c + 1) % 4, 0);
        src(c, 1);
        src(c, 0);
      end
    end
  endtask : t_trig
  task end_sim;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim
  initial forever #50 clk = ~clk;
  // Cuts a hang short after a generous cycle budget.
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      error_cnt++;
      end_sim;
    end
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs;
    t_trig;
    end_sim;
  end
endmodule : adc_trigger_source_select_bench
bind trig_source_select trig_sel_chk chk_i (.REF_CLK(REF_CLK), .RESET(RESET), .ADDR(ADDR),
  .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA), .EV_START(EV_START),
  .G1_START(G1_START), .BUFFERED_MODE(BUFFERED_MODE));
